// ---- rtl/pbseq_top.sv ----
// Push button power sequencer with debounce, blanking, timeout and lockout
`timescale 1ns/1ps
`include "pbseq_params.svh"
module pbseq_top
  import pbseq_pkg::*;
#(
  parameter bit EN_ACTIVE_HIGH = 1'b1,
  parameter int unsigned ON_DB_CYC = `PBSEQ_MS_CYC(`PBSEQ_ON_DB_MS),
  parameter int unsigned OFF_DB_CYC = `PBSEQ_MS_CYC(`PBSEQ_OFF_DB_MS),
  parameter int unsigned BLANK_CYC = `PBSEQ_MS_CYC(`PBSEQ_BLANK_MS),
  parameter int unsigned LOCKOUT_CYC = `PBSEQ_MS_CYC(`PBSEQ_LOCKOUT_MS),
  parameter int unsigned TIMEOUT_CYC = `PBSEQ_MS_CYC(`PBSEQ_TIMEOUT_MS),
  parameter int unsigned REQ_FILT_CYC = `PBSEQ_US_CYC(`PBSEQ_REQ_FILT_US)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic power_button_n,
  input wire logic shutdown_req_n,
  input wire logic [31:0] off_debounce_extend,
  input wire logic [31:0] shutdown_timeout_extend,
  output pbseq_pkg::pbseq_out_t pins_ff
);
  import pbseq_pkg::*;

  logic pb_s1_ff;
  logic pb_s2_ff;
  logic rq_s1_ff;
  logic rq_s2_ff;
  logic req_n;
  logic [31:0] tmr_ff;
  logic [31:0] db_ff;
  logic [31:0] hi_ff;
  pbseq_state_t state_ff;
  pbseq_state_t nxt_state;
  logic on_now;

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pb_s1_ff <= 1'h1;
      pb_s2_ff <= 1'h1;
      rq_s1_ff <= 1'h1;
      rq_s2_ff <= 1'h1;
    end
    else if (clk_en)
    begin
      pb_s1_ff <= power_button_n;
      pb_s2_ff <= pb_s1_ff;
      rq_s1_ff <= shutdown_req_n;
      rq_s2_ff <= rq_s1_ff;
    end
  end

  pbseq_filter #(
    .FILT_CYC(REQ_FILT_CYC)
  ) u_req_filt (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .din_n(rq_s2_ff),
    .dout_n(req_n)
  );

  // Button debounce counter, cleared by any high level
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      db_ff <= 32'h0;
    else if (clk_en)
    begin
      if (pb_s2_ff || (state_ff != nxt_state))
        db_ff <= 32'h0;
      else if (db_ff != 32'hffffffff)
        db_ff <= db_ff + 32'h1;
    end
  end

  // Button-high counter for the release debounce, cleared by any low level
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      hi_ff <= 32'h0;
    else if (clk_en)
    begin
      if (!pb_s2_ff || (state_ff != nxt_state))
        hi_ff <= 32'h0;
      else if (hi_ff != 32'hffffffff)
        hi_ff <= hi_ff + 32'h1;
    end
  end

  // Sequencing state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PBSEQ_OFF:
        if (db_ff >= ON_DB_CYC - 1 && !pb_s2_ff)
          nxt_state = PBSEQ_BLANK;
      PBSEQ_BLANK:
        if (tmr_ff >= BLANK_CYC - 1)
          nxt_state = req_n ? PBSEQ_RELEASE : PBSEQ_OFF;
      PBSEQ_RUN:
        if (!req_n)
          nxt_state = PBSEQ_LOCKOUT;
        else if (db_ff >= OFF_DB_CYC - 1 + off_debounce_extend && !pb_s2_ff)
          nxt_state = PBSEQ_SHUTDOWN;
      PBSEQ_SHUTDOWN:
        if (!req_n)
          nxt_state = PBSEQ_LOCKOUT;
        else if (tmr_ff >= TIMEOUT_CYC - 1 + shutdown_timeout_extend)
          nxt_state = PBSEQ_RELEASE;
      PBSEQ_LOCKOUT:
        if (tmr_ff >= LOCKOUT_CYC - 1)
          nxt_state = PBSEQ_RELEASE;
      PBSEQ_RELEASE:
        if (hi_ff >= OFF_DB_CYC - 1 && pb_s2_ff)
          nxt_state = (state_ff == PBSEQ_RELEASE && on_now) ? PBSEQ_RUN : PBSEQ_OFF;
      default:
        nxt_state = PBSEQ_OFF;
    endcase
  end

  // Release state waits for the button to be seen high, then settles
  assign on_now = pins_ff.power_en == EN_ACTIVE_HIGH;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= PBSEQ_OFF;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  // Period timer, restarted on each state change
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      tmr_ff <= 32'h0;
    else if (clk_en)
    begin
      if (state_ff != nxt_state)
        tmr_ff <= 32'h0;
      else if (tmr_ff != 32'hffffffff)
        tmr_ff <= tmr_ff + 32'h1;
    end
  end

  // Registered outputs with selectable enable polarity
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_ff.power_en <= ~EN_ACTIVE_HIGH;
      pins_ff.shutdown_int_n <= `PBSEQ_INT_RST;
    end
    else if (clk_en)
    begin
      if (nxt_state == PBSEQ_BLANK)
        pins_ff.power_en <= EN_ACTIVE_HIGH;
      else if (nxt_state == PBSEQ_OFF || nxt_state == PBSEQ_LOCKOUT)
        pins_ff.power_en <= ~EN_ACTIVE_HIGH;
      else if (state_ff == PBSEQ_SHUTDOWN && nxt_state == PBSEQ_RELEASE)
        pins_ff.power_en <= ~EN_ACTIVE_HIGH;
      pins_ff.shutdown_int_n <= (nxt_state != PBSEQ_SHUTDOWN);
    end
  end

  a_abort_drop: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && state_ff == PBSEQ_BLANK && nxt_state == PBSEQ_OFF) |=>
    (pins_ff.power_en == ~EN_ACTIVE_HIGH))
    else $error("Power-on abort did not drop enable");

  a_req_drop: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && state_ff == PBSEQ_RUN && !req_n) |=>
    (pins_ff.power_en == ~EN_ACTIVE_HIGH && state_ff == PBSEQ_LOCKOUT))
    else $error("Shutdown request did not drop enable");

  a_lockout_hold: assert property (@(posedge clock) disable iff (!arst_n)
    (state_ff == PBSEQ_LOCKOUT) |-> (pins_ff.power_en == ~EN_ACTIVE_HIGH))
    else $error("Enable asserted during lockout");

  a_int_low: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(pins_ff.shutdown_int_n) |-> (state_ff == PBSEQ_SHUTDOWN && tmr_ff == 32'h0))
    else $error("Interrupt fell outside shutdown entry");

  a_on_debounce: assert property (@(posedge clock) disable iff (!arst_n)
    (state_ff == PBSEQ_OFF && clk_en && nxt_state == PBSEQ_BLANK) |->
    (db_ff >= ON_DB_CYC - 1 && !pb_s2_ff))
    else $error("Enable asserted without full press");

  a_db_restart: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && pb_s2_ff) |=> (db_ff == 32'h0))
    else $error("Debounce did not restart on high");

  a_timeout_rel: assert property (@(posedge clock) disable iff (!arst_n)
    (state_ff == PBSEQ_SHUTDOWN && nxt_state == PBSEQ_RELEASE && clk_en) |=>
    (pins_ff.power_en == ~EN_ACTIVE_HIGH && pins_ff.shutdown_int_n))
    else $error("Timeout did not release enable");

  a_filt_short: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && $fell(req_n)) |->
    ($past(!rq_s2_ff)))
    else $error("Request accepted without low input");

  a_offdb_len: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && state_ff == PBSEQ_RUN && nxt_state == PBSEQ_SHUTDOWN) |->
    (db_ff >= OFF_DB_CYC - 1 + off_debounce_extend))
    else $error("Turn-off accepted early");
endmodule // pbseq_top

// ---- rtl/pbseq_params.svh ----
// Timing constants and reset values for the push button power sequencer
`ifndef PBSEQ_PARAMS_SVH
`define PBSEQ_PARAMS_SVH
`define PBSEQ_CLK_HZ 10000000
`define PBSEQ_ON_DB_MS 128
`define PBSEQ_OFF_DB_MS 32
`define PBSEQ_BLANK_MS 512
`define PBSEQ_LOCKOUT_MS 256
`define PBSEQ_TIMEOUT_MS 128
`define PBSEQ_REQ_FILT_US 30
`define PBSEQ_MS_CYC(ms) ((ms) * (`PBSEQ_CLK_HZ / 1000))
`define PBSEQ_US_CYC(us) (((us) * (`PBSEQ_CLK_HZ / 1000) + 999) / 1000)
`define PBSEQ_INT_RST 1'h1
`define PBSEQ_CNT_W 32
`endif

// ---- rtl/pbseq_pkg.sv ----
// Types shared by the push button power sequencer
package pbseq_pkg;
  typedef enum logic [2:0] {
    PBSEQ_OFF,
    PBSEQ_BLANK,
    PBSEQ_RUN,
    PBSEQ_SHUTDOWN,
    PBSEQ_LOCKOUT,
    PBSEQ_RELEASE
  } pbseq_state_t;

  typedef struct packed {
    logic power_en;
    logic shutdown_int_n;
  } pbseq_out_t;
endpackage

// ---- rtl/pbseq_filter.sv ----
// Low-pulse qualifier: output low only after input low for a set count
`timescale 1ns/1ps
`include "pbseq_params.svh"
module pbseq_filter #(
  parameter int unsigned FILT_CYC = 300
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic din_n,
  output logic dout_n
);
  logic [15:0] cnt_ff;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 16'h0;
      dout_n <= 1'h1;
    end
    else if (clk_en)
    begin
      if (din_n)
      begin
        cnt_ff <= 16'h0;
        dout_n <= 1'h1;
      end
      else if (cnt_ff >= 16'(FILT_CYC - 1))
        dout_n <= 1'h0;
      else
        cnt_ff <= cnt_ff + 16'h1;
    end
  end
endmodule // pbseq_filter

// ---- test/pbseq_partner.sv ----
// Push button and host model for the sequencer bench
`timescale 1ns/1ps
module pbseq_partner (
  input wire logic clock,
  input wire logic press,
  input wire logic host_up,
  input wire logic kill,
  output logic power_button_n,
  output logic shutdown_req_n
);
  // Host holds request low until host_up is set, then while kill is high
  always @(posedge clock)
  begin
    power_button_n <= ~press;
    shutdown_req_n <= host_up & ~kill;
  end
endmodule // pbseq_partner

// ---- test/pbseq_top_tb.sv ----
// Self-checking bench for the push button power sequencer
`timescale 1ns/1ps
module pbseq_top_tb;
  import pbseq_pkg::*;
  localparam int ON = 20;
  localparam int OFF = 10;
  localparam int BLK = 40;
  localparam int LCK = 30;
  localparam int TMO = 15;
  localparam int FLT = 5;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic clk_en = 1'h1;
  logic press = 1'h0;
  logic host_up = 1'h0;
  logic kill = 1'h0;
  logic power_button_n;
  logic shutdown_req_n;
  pbseq_out_t pins_ff;
  pbseq_out_t pins_low;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  always #50 clock = ~clock;
  pbseq_partner far (.clock(clock), .press(press), .host_up(host_up), .kill(kill),
    .power_button_n(power_button_n), .shutdown_req_n(shutdown_req_n));
  pbseq_top #(.ON_DB_CYC(ON), .OFF_DB_CYC(OFF), .BLANK_CYC(BLK), .LOCKOUT_CYC(LCK),
    .TIMEOUT_CYC(TMO), .REQ_FILT_CYC(FLT)) dut (.clock(clock), .arst_n(arst_n),
    .clk_en(clk_en), .power_button_n(power_button_n), .shutdown_req_n(shutdown_req_n),
    .off_debounce_extend(32'h4), .shutdown_timeout_extend(32'h3), .pins_ff(pins_ff));
  pbseq_top #(.EN_ACTIVE_HIGH(1'h0), .ON_DB_CYC(ON), .OFF_DB_CYC(OFF), .BLANK_CYC(BLK),
    .LOCKOUT_CYC(LCK), .TIMEOUT_CYC(TMO), .REQ_FILT_CYC(FLT)) dut_low (.clock(clock),
    .arst_n(arst_n), .clk_en(clk_en), .power_button_n(power_button_n),
    .shutdown_req_n(shutdown_req_n), .off_debounce_extend(32'h4),
    .shutdown_timeout_extend(32'h3), .pins_ff(pins_low));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic check_int(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s took %0d", $time, what, got);
    end
  endtask
  // Counts cycles until the chosen output reaches v
  task automatic wait_for(input bit use_int, input logic v, input int lim);
    n = 0;
    while ((use_int ? pins_ff.shutdown_int_n : pins_ff.power_en) !== v && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check_bit(pins_low.power_en, ~pins_ff.power_en, "polarity");
    check_bit(pins_low.shutdown_int_n, pins_ff.shutdown_int_n, "variant interrupt");
    if (n == lim)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic power_up();
    @(posedge clock);
    press <= 1'h1;
    wait_for(0, 1'h1, 60);
    press <= 1'h0;
    repeat (BLK + OFF + 10) @(posedge clock);
  endtask
  task automatic t_abort();
    @(posedge clock);
    press <= 1'h1;
    repeat (12) @(posedge clock);
    press <= 1'h0;
    repeat (3) @(posedge clock);
    press <= 1'h1;
    wait_for(0, 1'h1, 60);
    check_int(n, ON + 2, ON + 6, "power on");
    press <= 1'h0;
    wait_for(0, 1'h0, 80);
    check_int(n, BLK - 3, BLK + 3, "abort");
    $display("test abort done");
  endtask
  task automatic t_kill();
    host_up <= 1'h1;
    power_up();
    kill <= 1'h1;
    repeat (3) @(posedge clock);
    kill <= 1'h0;
    repeat (20) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h1, "glitch");
    @(posedge clock);
    kill <= 1'h1;
    wait_for(0, 1'h0, 40);
    check_int(n, FLT + 2, FLT + 6, "kill");
    kill <= 1'h0;
    press <= 1'h1;
    repeat (ON + 5) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h0, "lockout");
    press <= 1'h0;
    repeat (LCK + OFF + 10) @(posedge clock);
    $display("test kill done");
  endtask
  task automatic t_timeout();
    power_up();
    press <= 1'h1;
    wait_for(1, 1'h0, 60);
    check_int(n, OFF + 6, OFF + 10, "interrupt");
    press <= 1'h0;
    wait_for(0, 1'h0, 60);
    check_int(n, TMO + 1, TMO + 5, "timeout");
    $display("test timeout done");
  endtask
  task automatic t_freeze();
    repeat (OFF + 5) @(posedge clock);
    clk_en <= 1'h0;
    press <= 1'h1;
    repeat (ON + 10) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h0, "frozen");
    @(posedge clock);
    clk_en <= 1'h1;
    wait_for(0, 1'h1, 60);
    check_int(n, ON + 1, ON + 4, "resume");
    press <= 1'h0;
    @(posedge clock);
    arst_n <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h0, "mid reset enable");
    check_bit(pins_low.power_en, 1'h1, "mid reset variant enable");
    check_bit(pins_ff.shutdown_int_n, 1'h1, "mid reset interrupt");
    @(posedge clock);
    arst_n <= 1'h1;
    repeat (2) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h0, "after reset enable");
    check_bit(pins_ff.shutdown_int_n, 1'h1, "after reset interrupt");
    $display("test freeze done");
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    check_bit(pins_ff.power_en, 1'h0, "reset enable");
    check_bit(pins_ff.shutdown_int_n, 1'h1, "reset interrupt");
    check_bit(pins_low.power_en, 1'h1, "reset variant enable");
    @(posedge clock);
    arst_n <= 1'h1;
    t_abort();
    t_kill();
    t_timeout();
    t_freeze();
    tally_and_finish();
  end
endmodule // pbseq_top_tb
